// *** mpp_port_pins.sv ***
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Reset pin high 24 cycles resets
// - Analog port is input only, 8 bits
// - Analog port pins start analog after reset
// - Writing 0 makes pin digital input
// - Pull-up port: latch 1 pulls high, input
// - Wide bus port open drain, 1 floats
// - Wide bus carries address then data
// - Bus mode drives ones actively high
// - External irqs edge or level triggered
// - External irqs have two priority levels
// - Irq zero pin gates timer zero
// - Irq one pin gates timer one
// - Counter two counts falling edges
// - Receive pin input or sync bidirectional
// - Transmit pin data or sync clock
// - One analog pin is slave select
module mpp_port_pins
    import mpp_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int CNT2_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_i,
    output logic dev_reset_o,
    input wire mpp_pkg::mpp_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic [PORT_W-1:0] wide_bus_port_i,
    output logic [PORT_W-1:0] wide_bus_port_o,
    output logic [PORT_W-1:0] wide_bus_port_oe_o,
    output logic addr_latch_o,
    input wire logic [PORT_W-1:0] analog_input_port_i,
    output logic [PORT_W-1:0] analog_mode_o,
    input wire logic [3:0] pullup_port_i,
    output logic [3:0] pullup_port_o,
    output logic [3:0] pullup_port_oe_o,
    input wire logic ser_rx_out_i,
    input wire logic ser_rx_oe_i,
    input wire logic ser_tx_i,
    input wire logic ser_sclk_i,
    output logic ser_rx_o,
    output logic spi_slave_sel_o,
    output mpp_pkg::mpp_irq_t irq_info_o,
    output logic [CNT2_W-1:0] counter_two_o
);
    import mpp_pkg::*;

    logic [PORT_W-1:0] wb_pin_s;
    logic [PORT_W-1:0] an_pin_s;
    logic [3:0] pu_pin_s;
    logic rst_pin_s;

    // ==========================================
    // Input synchronisers
    mpp_sync #(.WIDTH(2 * PORT_W + 5)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({wide_bus_port_i, analog_input_port_i, pullup_port_i, reset_pin_i}),
        .sync_o({wb_pin_s, an_pin_s, pu_pin_s, rst_pin_s})
    );

    // ==========================================
    // Reset pin qualification
    logic [4:0] rst_cnt_q, rst_cnt_d;
    logic dev_rst_q, dev_rst_d;

    always_comb begin
        rst_cnt_d = rst_cnt_q;
        dev_rst_d = 1'b0;
        if (!rst_pin_s) begin
            rst_cnt_d = '0;
        end else if (rst_cnt_q < 5'(RESET_HOLD_CYCLES)) begin
            rst_cnt_d = rst_cnt_q + 5'd1;
        end
        if (rst_pin_s && rst_cnt_d == 5'(RESET_HOLD_CYCLES)) begin
            dev_rst_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_cnt_q <= '0;
            dev_rst_q <= 1'b0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            dev_rst_q <= dev_rst_d;
        end
    end

    assign dev_reset_o = dev_rst_q;
    logic soft_rst;
    assign soft_rst = rst_i | dev_rst_q;

    // ==========================================
    // Register file
    logic [PORT_W-1:0] wb_latch_q, wb_latch_d;
    logic [PORT_W-1:0] an_sel_q, an_sel_d;
    logic [3:0] pu_latch_q, pu_latch_d;
    logic [3:0] irq_cfg_q, irq_cfg_d;
    logic [3:0] alt_cfg_q, alt_cfg_d;
    logic [3:0] mask_q, mask_d;
    logic [3:0] status_q, status_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [3:0] ev;
    logic xm_start;
    logic [15:0] xm_wdata;
    logic [PORT_W-1:0] xm_rdata_q;
    logic [CNT2_W-1:0] cnt2_q;
    logic wr, rd;

    assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_q;
    assign rd = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~ack_q;

    always_comb begin
        wb_latch_d = wb_latch_q;
        an_sel_d = an_sel_q;
        pu_latch_d = pu_latch_q;
        irq_cfg_d = irq_cfg_q;
        alt_cfg_d = alt_cfg_q;
        mask_d = mask_q;
        status_d = status_q;
        xm_start = 1'b0;
        xm_wdata = '0;
        ack_d = wr | rd;
        rdat_d = '0;
        if (wr && wb_req_i.sel[0]) begin
            case (wb_req_i.adr)
                ADDR_WIDE_BUS_LATCH: wb_latch_d = wb_req_i.dat[PORT_W-1:0];
                ADDR_ANALOG_PORT: an_sel_d = an_sel_q & wb_req_i.dat[PORT_W-1:0];
                ADDR_PULLUP_LATCH: pu_latch_d = wb_req_i.dat[3:0];
                ADDR_IRQ_CFG: irq_cfg_d = wb_req_i.dat[3:0];
                ADDR_ALT_CFG: alt_cfg_d = wb_req_i.dat[3:0];
                ADDR_IRQ_MASK: mask_d = wb_req_i.dat[3:0];
                ADDR_IRQ_STATUS: status_d = status_q & ~wb_req_i.dat[3:0];
                default: ;
            endcase
        end
        if (wr && wb_req_i.adr == ADDR_XMEM && wb_req_i.sel[1:0] == 2'b11) begin
            xm_start = 1'b1;
            xm_wdata = wb_req_i.dat[15:0];
        end
        status_d = status_d | ev;
        if (rd) begin
            case (wb_req_i.adr)
                ADDR_WIDE_BUS_LATCH: rdat_d = 32'(wb_latch_q);
                ADDR_WIDE_BUS_PIN: rdat_d = 32'(wb_pin_s);
                ADDR_ANALOG_PORT: rdat_d = {16'h0, an_sel_q, an_pin_s & ~an_sel_q};
                ADDR_PULLUP_LATCH: rdat_d = 32'(pu_latch_q);
                ADDR_PULLUP_PIN: rdat_d = 32'(pu_pin_s);
                ADDR_IRQ_CFG: rdat_d = 32'(irq_cfg_q);
                ADDR_ALT_CFG: rdat_d = 32'(alt_cfg_q);
                ADDR_IRQ_STATUS: rdat_d = 32'(status_q);
                ADDR_IRQ_MASK: rdat_d = 32'(mask_q);
                ADDR_CNT2: rdat_d = 32'(cnt2_q);
                ADDR_XMEM: rdat_d = 32'(xm_rdata_q);
                default: rdat_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            wb_latch_q <= RST_LATCH;
            an_sel_q <= RST_ANALOG_SEL;
            pu_latch_q <= RST_LATCH[3:0];
            irq_cfg_q <= RST_IRQ_CFG;
            alt_cfg_q <= RST_ALT_CFG;
            mask_q <= RST_MASK;
            status_q <= RST_STATUS;
            ack_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            wb_latch_q <= wb_latch_d;
            an_sel_q <= an_sel_d;
            pu_latch_q <= pu_latch_d;
            irq_cfg_q <= irq_cfg_d;
            alt_cfg_q <= alt_cfg_d;
            mask_q <= mask_d;
            status_q <= status_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o = |(status_q & mask_q);
    assign analog_mode_o = an_sel_q;

    // ==========================================
    // Edge detection on pins
    logic [1:0] irq_prev_q;
    logic t2_prev_q;
    logic [1:0] irq_fall;
    logic t2_fall;
    logic t2_digital;

    assign t2_digital = ~an_sel_q[BIT_T2];
    assign irq_fall = irq_prev_q & ~pu_pin_s[BIT_IRQ1:BIT_IRQ0];
    assign t2_fall = t2_prev_q & ~an_pin_s[BIT_T2] & t2_digital;

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            irq_prev_q <= 2'b11;
            t2_prev_q <= 1'b1;
            cnt2_q <= '0;
        end else begin
            irq_prev_q <= pu_pin_s[BIT_IRQ1:BIT_IRQ0];
            t2_prev_q <= an_pin_s[BIT_T2];
            if (alt_cfg_q[ALT_CNT2_EN] && t2_fall) begin
                cnt2_q <= cnt2_q + CNT2_W'(1);
            end
        end
    end

    assign counter_two_o = cnt2_q;
    assign spi_slave_sel_o = an_pin_s[BIT_SLAVE_SEL] | an_sel_q[BIT_SLAVE_SEL];

    // Active-low interrupt requests, edge or level per config
    logic irq0_req, irq1_req;
    assign irq0_req = irq_cfg_q[IRQ_CFG_EDGE0] ? irq_fall[0] : ~pu_pin_s[BIT_IRQ0];
    assign irq1_req = irq_cfg_q[IRQ_CFG_EDGE1] ? irq_fall[1] : ~pu_pin_s[BIT_IRQ1];

    // ==========================================
    // External memory cycle
    mpp_xm_state_t xm_q, xm_d;
    logic [PORT_W-1:0] xm_out_q, xm_out_d;
    logic [PORT_W-1:0] xm_data_q, xm_data_d;
    logic [PORT_W-1:0] xm_rdata_d;
    logic xm_we_q, xm_we_d;
    logic [1:0] xm_cnt_q, xm_cnt_d;
    logic xm_done;

    always_comb begin
        xm_d = xm_q;
        xm_out_d = xm_out_q;
        xm_data_d = xm_data_q;
        xm_we_d = xm_we_q;
        xm_rdata_d = xm_rdata_q;
        xm_cnt_d = xm_cnt_q;
        xm_done = 1'b0;
        case (xm_q)
            MPP_XM_IDLE: begin
                if (xm_start) begin
                    xm_out_d = xm_wdata[PORT_W-1:0];
                    xm_data_d = xm_wdata[15:8];
                    xm_we_d = wb_req_i.dat[16];
                    xm_d = MPP_XM_ADDR;
                end
            end
            MPP_XM_ADDR: begin
                xm_out_d = xm_data_q;
                xm_d = MPP_XM_DATA;
            end
            MPP_XM_DATA: begin
                // Read waits out the pin synchroniser before taking the data
                // Write data stays on the bus for the whole phase
                xm_cnt_d = xm_cnt_q + 2'd1;
                if (xm_cnt_q == 2'(XM_DATA_CYCLES - 1)) begin
                    if (!xm_we_q) begin
                        xm_rdata_d = wb_pin_s;
                    end
                    xm_cnt_d = '0;
                    xm_d = MPP_XM_DONE;
                end
            end
            MPP_XM_DONE: begin
                xm_done = 1'b1;
                xm_d = MPP_XM_IDLE;
            end
            default: xm_d = MPP_XM_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            xm_q <= MPP_XM_IDLE;
            xm_out_q <= '0;
            xm_data_q <= '0;
            xm_we_q <= 1'b0;
            xm_rdata_q <= '0;
            xm_cnt_q <= '0;
        end else begin
            xm_cnt_q <= xm_cnt_d;
            xm_q <= xm_d;
            xm_out_q <= xm_out_d;
            xm_data_q <= xm_data_d;
            xm_we_q <= xm_we_d;
            xm_rdata_q <= xm_rdata_d;
        end
    end

    assign ev = {xm_done, t2_fall & alt_cfg_q[ALT_CNT2_EN], irq1_req, irq0_req};

    // ==========================================
    // Pin drivers
    logic bus_active;
    logic bus_drive;
    assign bus_active = (xm_q == MPP_XM_ADDR) || (xm_q == MPP_XM_DATA);
    assign bus_drive = (xm_q == MPP_XM_ADDR) || (xm_q == MPP_XM_DATA && xm_we_q);
    assign addr_latch_o = (xm_q == MPP_XM_ADDR);

    always_comb begin
        if (bus_drive) begin
            wide_bus_port_o = xm_out_q;
            wide_bus_port_oe_o = '1;
        end else if (bus_active) begin
            wide_bus_port_o = '0;
            wide_bus_port_oe_o = '0;
        end else begin
            wide_bus_port_o = '0;
            wide_bus_port_oe_o = ~wb_latch_q;
        end
    end

    // Serial alternates combine with the latch; latch must stay 1 to pass them
    logic rx_alt, tx_alt;
    assign rx_alt = alt_cfg_q[ALT_SER_SYNC] ? (ser_rx_oe_i ? ser_rx_out_i : 1'b1) : 1'b1;
    assign tx_alt = alt_cfg_q[ALT_SER_SYNC] ? ser_sclk_i : ser_tx_i;

    logic [3:0] pu_level;
    assign pu_level = pu_latch_q & {2'b11, tx_alt, rx_alt};
    assign pullup_port_o = pu_level;
    assign pullup_port_oe_o = ~pu_level;
    assign ser_rx_o = pu_pin_s[BIT_RXD];

    assign irq_info_o.gate0 = pu_pin_s[BIT_IRQ0] | ~alt_cfg_q[ALT_GATE0];
    assign irq_info_o.gate1 = pu_pin_s[BIT_IRQ1] | ~alt_cfg_q[ALT_GATE1];
    assign irq_info_o.irq0_level = ~pu_pin_s[BIT_IRQ0];
    assign irq_info_o.irq1_level = ~pu_pin_s[BIT_IRQ1];
    assign irq_info_o.irq0_event = irq0_req;
    assign irq_info_o.irq1_event = irq1_req;
    assign irq_info_o.irq0_high_prio = irq_cfg_q[IRQ_CFG_PRIO0];
    assign irq_info_o.irq1_high_prio = irq_cfg_q[IRQ_CFG_PRIO1];
endmodule
`default_nettype wire

// *** mpp_pkg.sv ***
package mpp_pkg;
    // ==========================================
    // Register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_WIDE_BUS_LATCH = 8'h00;
    localparam logic [7:0] ADDR_WIDE_BUS_PIN = 8'h04;
    localparam logic [7:0] ADDR_ANALOG_PORT = 8'h08;
    localparam logic [7:0] ADDR_PULLUP_LATCH = 8'h0c;
    localparam logic [7:0] ADDR_PULLUP_PIN = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CFG = 8'h14;
    localparam logic [7:0] ADDR_ALT_CFG = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_CNT2 = 8'h24;
    localparam logic [7:0] ADDR_XMEM = 8'h28;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_LATCH = 8'hff;
    localparam logic [7:0] RST_ANALOG_SEL = 8'hff;
    localparam logic [3:0] RST_IRQ_CFG = 4'h0;
    localparam logic [3:0] RST_ALT_CFG = 4'h0;
    localparam logic [3:0] RST_STATUS = 4'h0;
    localparam logic [3:0] RST_MASK = 4'h0;

    // ==========================================
    // Field positions
    localparam int IRQ_CFG_EDGE0 = 0;
    localparam int IRQ_CFG_EDGE1 = 1;
    localparam int IRQ_CFG_PRIO0 = 2;
    localparam int IRQ_CFG_PRIO1 = 3;
    localparam int ALT_GATE0 = 0;
    localparam int ALT_GATE1 = 1;
    localparam int ALT_CNT2_EN = 2;
    localparam int ALT_SER_SYNC = 3;
    localparam int ST_IRQ0 = 0;
    localparam int ST_IRQ1 = 1;
    localparam int ST_CNT2 = 2;
    localparam int ST_XMEM = 3;
    localparam int BIT_RXD = 0;
    localparam int BIT_TXD = 1;
    localparam int BIT_IRQ0 = 2;
    localparam int BIT_IRQ1 = 3;
    localparam int BIT_T2 = 0;
    localparam int BIT_SLAVE_SEL = 5;

    // ==========================================
    // Timing
    localparam int RESET_HOLD_CYCLES = 24;
    localparam int XM_DATA_CYCLES = 3;

    typedef enum logic [1:0] {
        MPP_XM_IDLE = 2'b00,
        MPP_XM_ADDR = 2'b01,
        MPP_XM_DATA = 2'b10,
        MPP_XM_DONE = 2'b11
    } mpp_xm_state_t;

    typedef struct packed {
        logic [7:0] adr;
        logic we;
        logic [31:0] dat;
        logic [3:0] sel;
        logic cyc;
        logic stb;
    } mpp_wb_req_t;

    typedef struct packed {
        logic gate0;
        logic gate1;
        logic irq0_level;
        logic irq1_level;
        logic irq0_event;
        logic irq1_event;
        logic irq0_high_prio;
        logic irq1_high_prio;
    } mpp_irq_t;
endpackage

// *** mpp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // ==========================================
    // Two flops per bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                end else begin
                    s1_q <= async_i[g];
                    s2_q <= s1_q;
                end
            end
            assign sync_o[g] = s2_q;
        end
    endgenerate
endmodule
`default_nettype wire

// *** mpp_port_pins_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpp_port_pins_chk
    import mpp_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_i,
    input wire logic dev_reset_o,
    input wire mpp_pkg::mpp_wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic [PORT_W-1:0] wide_bus_port_oe_o,
    input wire logic addr_latch_o,
    input wire logic [PORT_W-1:0] analog_mode_o,
    input wire logic [3:0] pullup_port_o,
    input wire logic [3:0] pullup_port_oe_o,
    input wire logic spi_slave_sel_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========================================
    // Bus handshake
    a_ack_after_req: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    // ==========================================
    // Pins
    a_reset_all_analog: assert property ($fell(rst_i) |-> analog_mode_o == 8'hff)
        else $error("analog mode not all set after reset");
    a_reset_pins_float: assert property ($fell(rst_i) |-> !(|wide_bus_port_oe_o))
        else $error("wide bus driven after reset");
    a_mode_only_clears: assert property (!dev_reset_o && !$past(dev_reset_o)
        |-> (analog_mode_o & ~$past(analog_mode_o)) == 8'h00)
        else $error("analog mode bit went back to analog");
    a_pullup_drive_low: assert property ((pullup_port_oe_o & pullup_port_o) == 4'h0)
        else $error("pullup port driven high");
    a_reset_pullup_high: assert property ($fell(rst_i) |-> pullup_port_oe_o[3:2] == 2'b00)
        else $error("pullup port pulled low after reset");
    a_addr_all_driven: assert property (addr_latch_o |-> wide_bus_port_oe_o == 8'hff)
        else $error("address phase not driven on all bits");
    a_addr_one_cycle: assert property (addr_latch_o |=> !addr_latch_o ##1 !addr_latch_o)
        else $error("address phase too long");
    a_select_analog_high: assert property (analog_mode_o[BIT_SLAVE_SEL] |-> spi_slave_sel_o)
        else $error("slave select low while pin analog");
    a_pin_reset_held: assert property ($rose(dev_reset_o)
        |-> $past(reset_pin_i, 24) && $past(reset_pin_i, 4))
        else $error("device reset without long pin pulse");
    a_pin_reset_release: assert property ($fell(reset_pin_i) |-> ##[1:6] !dev_reset_o)
        else $error("device reset stuck after pin release");
    cover property ($rose(dev_reset_o));
    cover property (addr_latch_o);
    cover property (irq_o);
endmodule
bind mpp_port_pins mpp_port_pins_chk #(.PORT_W(PORT_W)) u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reset_pin_i(reset_pin_i),
    .dev_reset_o(dev_reset_o),
    .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o),
    .irq_o(irq_o),
    .wide_bus_port_oe_o(wide_bus_port_oe_o),
    .addr_latch_o(addr_latch_o),
    .analog_mode_o(analog_mode_o),
    .pullup_port_o(pullup_port_o),
    .pullup_port_oe_o(pullup_port_oe_o),
    .spi_slave_sel_o(spi_slave_sel_o)
);
`default_nettype wire

// *** mpp_ext_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpp_ext_model (
    input wire logic clk_i,
    input wire logic [7:0] bus_o_i,
    input wire logic [7:0] bus_oe_i,
    input wire logic addr_latch_i,
    input wire logic ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] bus_pin_o,
    output logic [7:0] mem_addr_o,
    output logic [7:0] mem_data_o
);
    logic [7:0] last_q = 8'h00;
    logic data_ph_q = 1'b0;
    logic [1:0] rd_win_q = 2'd0;
    logic [7:0] idle_val;
    // Memory answers a read with the inverse of the address for three cycles
    // Released lines with no driver show the inverse of their last level
    assign idle_val = (rd_win_q != 2'd0) ? ~mem_addr_o : (ext_en_i ? ext_val_i : ~last_q);
    assign bus_pin_o = (bus_oe_i & bus_o_i) | (~bus_oe_i & idle_val);
    always @(posedge clk_i) begin
        last_q <= bus_pin_o;
        data_ph_q <= addr_latch_i;
        if (addr_latch_i) begin
            rd_win_q <= 2'd3;
        end else if (rd_win_q != 2'd0) begin
            rd_win_q <= rd_win_q - 2'd1;
        end
        if (addr_latch_i) begin
            mem_addr_o <= bus_pin_o;
        end
        if (data_ph_q && bus_oe_i == 8'hff) begin
            mem_data_o <= bus_pin_o;
        end
    end
endmodule
`default_nettype wire

// *** mpp_port_pins_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpp_port_pins_test;
    import mpp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rp, ack, irq, ale, ss, rx, dr, xen, srxo, srxe, stx, sclk;
    logic [31:0] rdat, seed, q, r;
    logic [7:0] wo, woe, wpin, apin, amode, xval, xa, xd;
    logic [3:0] po, poe, plow, ppin;
    logic [15:0] cnt, c0;
    mpp_wb_req_t req;
    mpp_irq_t info;
    int err_count = 0;
    int n_checks = 0;
    int tmo = 0;
    int n;
    logic [7:0] ra [6] = '{ADDR_WIDE_BUS_LATCH, ADDR_IRQ_CFG, ADDR_ALT_CFG, ADDR_IRQ_STATUS,
        ADDR_IRQ_MASK, 8'h3c};
    logic [7:0] rv [6] = '{RST_LATCH, 8'(RST_IRQ_CFG), 8'(RST_ALT_CFG), 8'(RST_STATUS),
        8'(RST_MASK), 8'h00};
    always #50 clk_i = ~clk_i;
    assign ppin = (poe & po) | (~poe & ~plow);
    mpp_port_pins DUT (
        .clk_i(clk_i), .rst_i(rst_i), .reset_pin_i(rp), .dev_reset_o(dr),
        .wb_req_i(req), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .wide_bus_port_i(wpin), .wide_bus_port_o(wo), .wide_bus_port_oe_o(woe),
        .addr_latch_o(ale), .analog_input_port_i(apin), .analog_mode_o(amode),
        .pullup_port_i(ppin), .pullup_port_o(po), .pullup_port_oe_o(poe),
        .ser_rx_out_i(srxo), .ser_rx_oe_i(srxe), .ser_tx_i(stx), .ser_sclk_i(sclk),
        .ser_rx_o(rx), .spi_slave_sel_o(ss), .irq_info_o(info), .counter_two_o(cnt)
    );
    mpp_ext_model u_ext (
        .clk_i(clk_i), .bus_o_i(wo), .bus_oe_i(woe), .addr_latch_i(ale), .ext_en_i(xen),
        .ext_val_i(xval), .bus_pin_o(wpin), .mem_addr_o(xa), .mem_data_o(xd)
    );
    // ==========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] rd);
        req.adr <= a;
        req.we <= w;
        req.dat <= d;
        req.sel <= 4'hf;
        req.cyc <= 1'b1;
        req.stb <= 1'b1;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = rdat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wrap_up();
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        tmo <= tmo + 1;
        if (tmo == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        seed = 32'h160d;
        rp = 1'b0; xen = 1'b0; xval = 8'h00; apin = 8'hff; plow = 4'h0;
        srxo = 1'b1; srxe = 1'b0; stx = 1'b1; sclk = 1'b1; req = '0;
        tick(12);
        rst_i <= 1'b0;
        tick(1);
        for (int i = 0; i < 6; i++) begin
            wb(ra[i], 1'b0, 32'h0, q);
            chk("reset value", q[7:0], rv[i]);
        end
        chk("unmapped read", q, 32'h0);
        seed = xs(seed);
        r = seed & 32'hfe;
        wb(ADDR_ANALOG_PORT, 1'b1, r, q);
        wb(ADDR_ANALOG_PORT, 1'b1, 32'hff, q);
        seed = xs(seed);
        apin <= seed[7:0] | 8'h01;
        tick(4);
        wb(ADDR_ANALOG_PORT, 1'b0, 32'h0, q);
        chk("analog mode", amode, r[7:0]);
        chk("analog read", q[15:0], {r[7:0], apin & ~r[7:0]});
        chk("slave select", ss, r[5] ? 1'b1 : apin[5]);
        seed = xs(seed);
        wb(ADDR_WIDE_BUS_LATCH, 1'b1, seed & 32'hff, q);
        tick(1);
        chk("wide enable", woe, 8'(~seed[7:0]));
        chk("wide drive", wo & woe, 8'h00);
        wb(ADDR_WIDE_BUS_LATCH, 1'b1, 32'hff, q);
        xen <= 1'b1;
        xval <= seed[15:8];
        tick(4);
        wb(ADDR_WIDE_BUS_PIN, 1'b0, 32'h0, q);
        chk("wide input", q[7:0], xval);
        xen <= 1'b0;
        seed = xs(seed);
        wb(ADDR_XMEM, 1'b1, {15'h0, 1'b1, seed[15:0]}, q);
        tick(5);
        chk("xmem addr", xa, seed[7:0]);
        chk("xmem data", xd, seed[15:8]);
        wb(ADDR_XMEM, 1'b1, {16'h0, seed[31:16]}, q);
        tick(7);
        wb(ADDR_XMEM, 1'b0, 32'h0, q);
        chk("xmem read", q[7:0], 8'(~seed[23:16]));
        wb(ADDR_PULLUP_LATCH, 1'b1, seed & 32'hf, q);
        tick(1);
        chk("pullup pins", ppin, seed[3:0]);
        wb(ADDR_PULLUP_LATCH, 1'b1, 32'hf, q);
        stx <= 1'b0;
        tick(3);
        chk("txd async", ppin[BIT_TXD], 1'b0);
        stx <= 1'b1;
        wb(ADDR_ALT_CFG, 1'b1, 32'h8, q);
        sclk <= 1'b0;
        srxe <= 1'b1;
        srxo <= 1'b0;
        tick(3);
        chk("sync pins", ppin[1:0], 2'b00);
        sclk <= 1'b1;
        srxe <= 1'b0;
        wb(ADDR_ALT_CFG, 1'b1, 32'h0, q);
        plow[BIT_RXD] <= 1'b1;
        tick(4);
        chk("rxd input", {ppin[1:0], rx}, 3'b100);
        plow[BIT_RXD] <= 1'b0;
        wb(ADDR_IRQ_MASK, 1'b1, 32'hf, q);
        seed = xs(seed);
        wb(ADDR_IRQ_CFG, 1'b1, {28'h0, seed[3:2], 2'b01}, q);
        chk("irq prio", {info.irq1_high_prio, info.irq0_high_prio}, seed[3:2]);
        plow[3:2] <= 2'b11;
        tick(5);
        chk("irq level", {irq, info.irq1_event, info.irq0_event, info.irq1_level, info.irq0_level},
            5'b11011);
        wb(ADDR_IRQ_STATUS, 1'b1, 32'h3, q);
        wb(ADDR_IRQ_STATUS, 1'b0, 32'h0, q);
        chk("irq status", q[1:0], 2'b10);
        wb(ADDR_ALT_CFG, 1'b1, 32'h3, q);
        tick(1);
        chk("gate low", {info.gate1, info.gate0}, 2'b00);
        plow[3:2] <= 2'b00;
        tick(4);
        chk("gate high", {info.gate1, info.gate0}, 2'b11);
        wb(ADDR_IRQ_MASK, 1'b1, 32'h0, q);
        chk("irq masked", irq, 1'b0);
        wb(ADDR_ALT_CFG, 1'b1, 32'h4, q);
        c0 = cnt;
        n = int'(seed[6:4]) + 1;
        repeat (n) begin
            apin[BIT_T2] <= 1'b0;
            tick(2);
            apin[BIT_T2] <= 1'b1;
            tick(2);
        end
        tick(4);
        chk("counter two", cnt - c0, n);
        wb(ADDR_WIDE_BUS_LATCH, 1'b1, 32'h0, q);
        rp <= 1'b1;
        tick(20);
        rp <= 1'b0;
        tick(4);
        chk("short reset pin", {dr, woe}, 9'h0ff);
        rp <= 1'b1;
        tick(32);
        chk("device reset", dr, 1'b1);
        rp <= 1'b0;
        tick(8);
        chk("after device reset", {dr, woe, amode}, 17'h000ff);
        wrap_up();
    end
endmodule
`default_nettype wire
